// >>> include/pipe_ctrl_consts.svh
// Constants for the five-stage pipeline control block
`ifndef PIPE_CTRL_CONSTS_SVH
`define PIPE_CTRL_CONSTS_SVH
`define RESET_PC 32'h0000_0000
`define EXC_VECTOR 32'h0000_0080
`define ZERO_REG 5'h00
`define LINK_REG 5'h1F
`define RS_LSB 21
`define RT_LSB 16
`define RD_LSB 11
`define REG_IDX_W 5
`define JUMP_IDX_W 26
`define UNMAPPED_SEG_BIT 31
`define PHYS_ADDR_W 29
`define WORD_BYTES 3'h4
`define SEQ_OFFSET 32'h0000_0004
`define LINK_OFFSET 32'h0000_0008
`define STRAP_CAPTURE 2'h2
`define STRAP_DONE 2'h3
`define BIG_ENDIAN_RESET 1'b1
`endif

// >>> include/pipe_ctrl_pkg.sv
// Types shared by the pipeline control block
package pipe_ctrl_pkg;
	typedef enum logic [1:0] {FMT_REG = 2'b00, FMT_IMM = 2'b01, FMT_JUMP = 2'b10} fmt_t;
	typedef enum logic [1:0] {MEM_NONE = 2'b00, MEM_LOAD = 2'b01, MEM_STORE = 2'b10} mem_kind_t;
	typedef enum logic [1:0] {PART_WHOLE = 2'b00, PART_LEFT = 2'b01, PART_RIGHT = 2'b10} part_t;
	typedef enum logic [1:0] {BR_NONE = 2'b00, BR_JUMP = 2'b01, BR_EQ = 2'b10, BR_NE = 2'b11} branch_kind_t;
	typedef struct packed {
		fmt_t fmt;
		mem_kind_t mem_kind;
		logic [2:0] size;
		part_t part;
		logic signed_load;
		logic writes;
		logic link;
		logic zero_ext;
		branch_kind_t branch;
		logic reads_hilo;
		logic starts_muldiv;
		logic [3:0] alu_op;
	} hint_t;
	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		hint_t hint;
		logic [4:0] dest;
		logic [31:0] op_a;
		logic [31:0] op_b;
		logic [31:0] rt_val;
		logic [15:0] imm;
	} ex_stage_t;
	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		hint_t hint;
		logic [4:0] dest;
		logic [31:0] result;
		logic [31:0] rt_val;
		logic [2:0] size;
		logic [1:0] low_lane;
		logic exc;
	} mem_stage_t;
	typedef struct packed {
		logic valid;
		logic is_load;
		logic writes;
		logic [4:0] dest;
		logic [31:0] data;
	} wb_stage_t;
endpackage : pipe_ctrl_pkg

// >>> src/pipe_ctrl.sv
// Five-stage pipeline control: sequencing, forwarding, interlock, delay slots, exceptions, byte lanes
//
// Overview of operation
// [RL1] Five stages: fetch, read, execute, access, write-back
// [RL2] Fetch translates address, reads instruction cache
// [RL3] Read stage decodes, reads register file
// [RL4] Data cache touched only by loads/stores
// [RL5] Write-back stage writes register file
// [RL6] New instruction may start every cycle
// [RL7] Forward execute result, no stall
// [RL8] Product register reads wait for multiply/divide
// [RL9] Load result usable two instructions later
// [RL10] Left/right load merges with preceding load
// [RL11] One delay slot after jump or branch
// [RL12] Exception: older complete, younger abort
// [RL13] One aligned word, three formats
// [RL14] Address is base plus signed offset
// [RL15] Big-endian word at 00: all lanes
// [RL16] Big-endian tri-byte: 00 lanes 3-1, 01 2-0
// [RL17] Big-endian halfword: 00 lanes 3-2, 10 1-0
// [RL18] Big-endian byte: exactly one lane
// [RL19] Lane enables show used bytes, legal combos
// [RL20] Little-endian lane mapping is mirrored
// [RL21] Order strapped at reset, user flip
// [RL22] Aborted never write; zero register never forwarded
`timescale 1ns/1ps
`default_nettype none
`include "pipe_ctrl_consts.svh"

module pipe_ctrl
	import pipe_ctrl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic endian_strap,
	input wire logic user_mode,
	input wire logic user_byte_order_flip,
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	input wire logic [31:0] icache_word,
	input wire logic icache_valid,
	output logic [31:0] rd_instr,
	input wire hint_t rd_hint,
	output logic [4:0] rf_raddr_a,
	output logic [4:0] rf_raddr_b,
	input wire logic [31:0] rf_rdata_a,
	input wire logic [31:0] rf_rdata_b,
	output logic [31:0] alu_op_a,
	output logic [31:0] alu_op_b,
	output logic [3:0] alu_ctl,
	input wire logic [31:0] alu_result,
	input wire logic alu_overflow,
	input wire logic muldiv_busy,
	output logic dmem_req,
	output logic dmem_we,
	output logic [31:0] dmem_addr,
	output logic [3:0] byte_lane_enable,
	output logic [31:0] dmem_wdata,
	input wire logic [31:0] dmem_rdata,
	input wire logic dmem_ready,
	output logic rf_we,
	output logic [4:0] rf_waddr,
	output logic [31:0] rf_wdata,
	output logic exc_taken,
	output logic [31:0] exc_pc
);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [5:0] byte_shift(input logic [2:0] n);
		byte_shift = {n, 3'b000};
	endfunction : byte_shift

	function automatic logic [31:0] translate(input logic [31:0] va);
		translate = va[`UNMAPPED_SEG_BIT] ? {3'b000, va[`PHYS_ADDR_W-1:0]} : va;
	endfunction : translate

	function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] start, input logic big);
		logic [3:0] span;
		span = 4'hF >> (`WORD_BYTES - size);
		lane_mask = big ? ((span << (`WORD_BYTES - size)) >> start) : (span << start);
	endfunction : lane_mask

	////////////////////////////////////////////////////////////////////////////
	logic strap_meta;
	logic strap_sync;
	logic [1:0] strap_settle;
	logic strap_big;
	logic [31:0] pc;
	logic rd_valid;
	logic [31:0] rd_pc;
	ex_stage_t ex;
	mem_stage_t mem;
	wb_stage_t wb;
	logic mem_wait;
	logic flush;
	logic hilo_stall;
	logic rd_hold;
	logic rd_advance;
	logic [31:0] fwd_a;
	logic [31:0] fwd_b;
	logic take_branch;
	logic [31:0] branch_target;
	logic [31:0] ex_result;
	logic [31:0] mem_value;

	assign rf_raddr_a = rd_instr[`RS_LSB +: `REG_IDX_W];
	assign rf_raddr_b = rd_instr[`RT_LSB +: `REG_IDX_W];
	assign alu_op_a = ex.op_a;
	assign alu_op_b = ex.op_b;
	assign alu_ctl = ex.hint.alu_op;
	assign dmem_addr = mem.result;
	assign rf_waddr = wb.dest;
	assign rf_wdata = wb.data;

	////////////////////////////////////////////////////////////////////////////
	// [RL21] Strap synchroniser
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
		end else begin
			strap_meta <= endian_strap;
			strap_sync <= strap_meta;
		end
	end

	// [RL21] Order caught after release
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_settle <= 2'h0;
			strap_big <= `BIG_ENDIAN_RESET;
		end else if (strap_settle != `STRAP_DONE) begin
			strap_settle <= strap_settle + 2'h1;
			if (strap_settle == `STRAP_CAPTURE) begin
				strap_big <= strap_sync;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// [RL8] Product register interlock
	assign hilo_stall = rd_valid && rd_hint.reads_hilo && (muldiv_busy || (ex.valid && ex.hint.starts_muldiv));
	assign mem_wait = dmem_req && !dmem_ready;
	// [RL12] Exception taken at access stage
	assign flush = mem.valid && mem.exc;
	assign rd_hold = hilo_stall || (rd_valid && rd_hint.branch != BR_NONE && !icache_valid);
	assign rd_advance = !flush && !mem_wait && !rd_hold;
	assign ex_result = ex.hint.link ? ex.pc + `LINK_OFFSET : alu_result;

	// [RL7] Forward newest value
	// [RL9] Loads not forwarded from execute
	function automatic logic [31:0] forward(input logic [4:0] src, input logic [31:0] rf_val);
		// [RL22] Zero register never forwarded
		if (src == `ZERO_REG) begin
			forward = 32'h0000_0000;
		end else if (ex.valid && ex.hint.writes && ex.hint.mem_kind != MEM_LOAD && ex.dest == src) begin
			forward = ex_result;
		end else if (mem.valid && mem.hint.writes && mem.dest == src) begin
			forward = mem_value;
		end else if (wb.valid && wb.writes && wb.dest == src) begin
			forward = wb.data;
		end else begin
			forward = rf_val;
		end
	endfunction : forward

	// [RL11] Branch resolved in read stage
	always_comb begin
		fwd_a = forward(rf_raddr_a, rf_rdata_a);
		fwd_b = forward(rf_raddr_b, rf_rdata_b);
		branch_target = rd_pc + `SEQ_OFFSET + {{14{rd_instr[15]}}, rd_instr[15:0], 2'b00};
		unique case (rd_hint.branch)
			BR_NONE: take_branch = 1'b0;
			BR_JUMP: begin
				take_branch = 1'b1;
				branch_target = {rd_pc[31:28], rd_instr[`JUMP_IDX_W-1:0], 2'b00};
			end
			BR_EQ: take_branch = fwd_a == fwd_b;
			BR_NE: take_branch = fwd_a != fwd_b;
		endcase
		take_branch = take_branch && rd_valid;
	end

	////////////////////////////////////////////////////////////////////////////
	// [RL2] Fetch and translate
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= `RESET_PC;
			fetch_addr <= `RESET_PC;
			fetch_req <= 1'b0;
		end else begin
			fetch_req <= 1'b1;
			if (flush) begin
				pc <= `EXC_VECTOR;
				fetch_addr <= translate(`EXC_VECTOR);
			end else if (rd_advance && take_branch) begin
				pc <= branch_target;
				fetch_addr <= translate(branch_target);
			// [RL6] Next word each cycle
			end else if (rd_advance && icache_valid && fetch_req) begin
				pc <= pc + `SEQ_OFFSET;
				fetch_addr <= translate(pc + `SEQ_OFFSET);
			end
		end
	end

	// [RL1] Stage registers advance together except on a read-stage hold, which holds read and sends a bubble to execute
	// [RL13] One word per instruction
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_pc <= `RESET_PC;
			rd_instr <= 32'h0000_0000;
		end else if (flush) begin
			rd_valid <= 1'b0;
		end else if (rd_advance) begin
			rd_valid <= icache_valid && fetch_req;
			rd_pc <= pc;
			rd_instr <= icache_word;
		end
	end

	// [RL3] Decode fields, latch operands
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ex <= '0;
		end else if (flush || (!mem_wait && rd_hold)) begin
			ex.valid <= 1'b0;
		end else if (!mem_wait) begin
			ex.valid <= rd_valid;
			ex.pc <= rd_pc;
			ex.hint <= rd_hint;
			ex.op_a <= fwd_a;
			ex.rt_val <= fwd_b;
			ex.imm <= rd_instr[15:0];
			unique case (rd_hint.fmt)
				FMT_REG: ex.dest <= rd_instr[`RD_LSB +: `REG_IDX_W];
				FMT_IMM: ex.dest <= rf_raddr_b;
				FMT_JUMP: ex.dest <= rd_hint.link ? `LINK_REG : `ZERO_REG;
				default: ex.dest <= `ZERO_REG;
			endcase
			if (rd_hint.fmt == FMT_IMM) begin
				ex.op_b <= rd_hint.zero_ext ? {16'h0000, rd_instr[15:0]} : {{16{rd_instr[15]}}, rd_instr[15:0]};
			end else begin
				ex.op_b <= fwd_b;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic big;
	logic [31:0] ea;
	logic [2:0] acc_size;
	logic [1:0] acc_start;
	logic [1:0] acc_low;
	logic misaligned;
	logic ex_exc;
	logic [31:0] store_pre;

	// [RL14] Base plus signed offset
	// [RL21] User flip of byte order
	always_comb begin
		big = strap_big ^ (user_mode && user_byte_order_flip);
		ea = ex.op_a + {{16{ex.imm[15]}}, ex.imm};
		acc_size = ex.hint.size;
		acc_start = ea[1:0];
		if (ex.hint.part != PART_WHOLE) begin
			if ((ex.hint.part == PART_LEFT) == big) begin
				acc_size = `WORD_BYTES - {1'b0, ea[1:0]};
			end else begin
				acc_size = {1'b0, ea[1:0]} + 3'h1;
				acc_start = 2'h0;
			end
		end
		acc_low = big ? 2'(`WORD_BYTES - {1'b0, acc_start} - acc_size) : acc_start;
		// [RL19] Only listed combinations legal
		misaligned = ex.hint.part == PART_WHOLE &&
			((acc_size == `WORD_BYTES && ea[1:0] != 2'h0) || (acc_size == 3'h2 && ea[0]) || (acc_size == 3'h3 && ea[1]));
		ex_exc = ex.valid && (alu_overflow || (misaligned && ex.hint.mem_kind != MEM_NONE));
		store_pre = ex.hint.part == PART_LEFT ? ex.rt_val >> byte_shift(`WORD_BYTES - acc_size) : ex.rt_val;
	end

	// [RL4] Cache access for loads, stores only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem <= '0;
			dmem_req <= 1'b0;
			dmem_we <= 1'b0;
			byte_lane_enable <= 4'h0;
			dmem_wdata <= 32'h0000_0000;
		end else if (flush) begin
			mem.valid <= 1'b0;
			dmem_req <= 1'b0;
			dmem_we <= 1'b0;
		end else if (!mem_wait) begin
			mem.valid <= ex.valid;
			mem.pc <= ex.pc;
			mem.hint <= ex.hint;
			mem.dest <= ex.dest;
			mem.rt_val <= ex.rt_val;
			mem.size <= acc_size;
			mem.low_lane <= acc_low;
			mem.exc <= ex_exc;
			mem.result <= ex.hint.mem_kind != MEM_NONE ? ea : ex_result;
			dmem_req <= ex.valid && !ex_exc && ex.hint.mem_kind != MEM_NONE;
			dmem_we <= ex.valid && !ex_exc && ex.hint.mem_kind == MEM_STORE;
			// [RL15] [RL16] [RL17] [RL18] [RL20] Lane enables
			byte_lane_enable <= lane_mask(acc_size, acc_start, big);
			dmem_wdata <= store_pre << byte_shift({1'b0, acc_low});
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic [31:0] aligned;
	logic [31:0] merge_base;
	logic [31:0] keep_mask;

	always_comb begin
		aligned = dmem_rdata >> byte_shift({1'b0, mem.low_lane});
		merge_base = mem.rt_val;
		// [RL10] Merge against preceding load
		if (wb.valid && wb.is_load && wb.dest == mem.dest && mem.dest != `ZERO_REG) begin
			merge_base = wb.data;
		end
		keep_mask = 32'h0000_0000;
		mem_value = mem.result;
		if (mem.hint.mem_kind == MEM_LOAD) begin
			unique case (mem.hint.part)
				PART_LEFT: begin
					keep_mask = 32'hFFFF_FFFF >> byte_shift(mem.size);
					mem_value = (aligned << byte_shift(`WORD_BYTES - mem.size)) | (merge_base & keep_mask);
				end
				PART_RIGHT: begin
					keep_mask = ~(32'hFFFF_FFFF >> byte_shift(`WORD_BYTES - mem.size));
					mem_value = (aligned & ~keep_mask) | (merge_base & keep_mask);
				end
				default: begin
					if (mem.size == 3'h1) begin
						mem_value = {{24{mem.hint.signed_load && aligned[7]}}, aligned[7:0]};
					end else if (mem.size == 3'h2) begin
						mem_value = {{16{mem.hint.signed_load && aligned[15]}}, aligned[15:0]};
					end else begin
						mem_value = aligned;
					end
				end
			endcase
		end
	end

	// [RL5] Write-back into register file
	// [RL22] Aborted instructions never write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb <= '0;
			rf_we <= 1'b0;
		end else begin
			rf_we <= !mem_wait && mem.valid && !mem.exc && mem.hint.writes && mem.dest != `ZERO_REG;
			if (!mem_wait) begin
				wb.valid <= mem.valid && !mem.exc;
				wb.is_load <= mem.hint.mem_kind == MEM_LOAD;
				wb.writes <= mem.hint.writes;
				wb.dest <= mem.dest;
				wb.data <= mem_value;
			end
		end
	end

	// [RL12] Report exception point
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			exc_taken <= 1'b0;
			exc_pc <= `RESET_PC;
		end else begin
			exc_taken <= flush;
			if (flush) begin
				exc_pc <= mem.pc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_branch_in_read;
		take_branch && rd_advance;
	endsequence
	sequence s_target_fetched(logic [31:0] t);
		##1 pc == t;
	endsequence

	property p_branch_slot;
		logic [31:0] t;
		(s_branch_in_read, t = branch_target) |-> s_target_fetched(t) ##0 rd_valid && rd_pc == $past(pc);
	endproperty
	a_branch_slot: assert property (p_branch_slot) else $error("delay slot or target wrong"); // [RL11]

	property p_hilo_hold;
		hilo_stall && !flush && !mem_wait |=> $stable(rd_instr) && !ex.valid;
	endproperty
	a_hilo_hold: assert property (p_hilo_hold) else $error("product read not held"); // [RL8]

	property p_forward;
		rd_advance && rd_valid && ex.valid && ex.hint.writes && ex.hint.mem_kind != MEM_LOAD &&
			ex.dest == rf_raddr_a && rf_raddr_a != `ZERO_REG |=> ex.op_a == $past(ex_result);
	endproperty
	a_forward: assert property (p_forward) else $error("execute result not forwarded"); // [RL7]

	property p_zero_write;
		rf_we |-> rf_waddr != `ZERO_REG && $past(mem.valid) && !$past(mem.exc);
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("illegal register write"); // [RL22]

	property p_exc_abort;
		flush |=> !mem.valid && !ex.valid && !rd_valid && !dmem_req && !rf_we && pc == `EXC_VECTOR;
	endproperty
	a_exc_abort: assert property (p_exc_abort) else $error("younger work not aborted"); // [RL12]

	property p_access_only_ls;
		dmem_req |-> mem.valid && mem.hint.mem_kind != MEM_NONE && !mem.exc;
	endproperty
	a_access_only_ls: assert property (p_access_only_ls) else $error("cache access by non-memory op"); // [RL4]

	property p_word_lanes;
		dmem_req && mem.size == `WORD_BYTES |-> byte_lane_enable == 4'hF && dmem_addr[1:0] == 2'h0;
	endproperty
	a_word_lanes: assert property (p_word_lanes) else $error("word access lanes wrong"); // [RL15]

	property p_byte_lane;
		dmem_req && mem.size == 3'h1 |-> $onehot(byte_lane_enable) && byte_lane_enable[mem.low_lane];
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("byte access lane wrong"); // [RL18]

	property p_issue_rate;
		rd_advance && icache_valid && fetch_req |=> rd_valid ##1
			($past(flush) || $past(rd_hold) || $past(mem_wait) || ex.valid);
	endproperty
	a_issue_rate: assert property (p_issue_rate) else $error("instruction not issued"); // [RL6]

endmodule : pipe_ctrl
`default_nettype wire

// >>> test/far_side.sv
// Behavioural caches, register file, decoder and ALU facing the pipeline control
`timescale 1ns/1ps
`default_nettype none

module far_side
	import pipe_ctrl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [31:0] fetch_addr,
	output logic [31:0] icache_word,
	output logic icache_valid,
	input wire logic [31:0] rd_instr,
	output hint_t rd_hint,
	input wire logic [4:0] rf_raddr_a,
	input wire logic [4:0] rf_raddr_b,
	output logic [31:0] rf_rdata_a,
	output logic [31:0] rf_rdata_b,
	input wire logic [31:0] alu_op_a,
	input wire logic [31:0] alu_op_b,
	output logic [31:0] alu_result,
	output logic alu_overflow,
	input wire logic dmem_req,
	input wire logic dmem_we,
	input wire logic [31:0] dmem_addr,
	input wire logic [3:0] byte_lane_enable,
	input wire logic [31:0] dmem_wdata,
	output logic [31:0] dmem_rdata,
	output logic dmem_ready,
	input wire logic rf_we,
	input wire logic [4:0] rf_waddr,
	input wire logic [31:0] rf_wdata
);
	logic [31:0] imem [256];
	logic [31:0] rf [32];
	logic [31:0] dmem [256];
	logic [3:0] lane_log [16];
	int nlog = 0;
	int dmem_wait = 0;
	int wcnt = 0;

	// Op in [31:28], size-1 in [27:26]
	function automatic hint_t dec(input logic [31:0] w);
		hint_t h;
		h = '0;
		h.size = {1'b0, w[27:26]} + 3'h1;
		case (w[31:28])
			4'h1: begin h.fmt = FMT_IMM; h.writes = 1'b1; end
			4'h2: h.writes = 1'b1;
			4'h3: begin h.fmt = FMT_IMM; h.mem_kind = MEM_LOAD; h.writes = 1'b1; end
			4'h4: begin h.fmt = FMT_IMM; h.mem_kind = MEM_STORE; end
			4'h5: begin h.fmt = FMT_JUMP; h.branch = BR_JUMP; end
			4'h7: begin h.reads_hilo = 1'b1; h.writes = 1'b1; end
			default: h.size = 3'h0;
		endcase
		return h;
	endfunction : dec

	assign icache_word = imem[fetch_addr[9:2]];
	assign icache_valid = 1'b1;
	assign rd_hint = dec(rd_instr);
	assign rf_rdata_a = rf[rf_raddr_a];
	assign rf_rdata_b = rf[rf_raddr_b];
	assign alu_result = alu_op_a + alu_op_b;
	assign alu_overflow = (alu_op_a[31] == alu_op_b[31]) && (alu_result[31] != alu_op_a[31]);
	assign dmem_ready = dmem_req && (wcnt >= dmem_wait);
	assign dmem_rdata = dmem_ready ? dmem[dmem_addr[9:2]] : ~dmem[dmem_addr[9:2]];

	always @(posedge ref_clk) begin
		if (dmem_req && !dmem_ready)
			wcnt <= wcnt + 1;
		else
			wcnt <= 0;
		if (dmem_ready && dmem_we) begin
			lane_log[nlog[3:0]] <= byte_lane_enable;
			nlog <= nlog + 1;
			for (int b = 0; b < 4; b++)
				if (byte_lane_enable[b])
					dmem[dmem_addr[9:2]][8*b +: 8] <= dmem_wdata[8*b +: 8];
		end
	end

	always @(posedge ref_clk) begin
		if (rf_we && rf_waddr != 5'h00)
			rf[rf_waddr] <= rf_wdata;
	end
endmodule : far_side
`default_nettype wire

// >>> test/test_five_stage_pipeline_control.sv
// Self-checking bench for the pipeline control block
`timescale 1ns/1ps
`default_nettype none

module test_five_stage_pipeline_control;
	import pipe_ctrl_pkg::*;
	logic ref_clk, rst_n, endian_strap, user_mode, user_byte_order_flip, muldiv_busy;
	logic fetch_req, icache_valid, alu_overflow, dmem_req, dmem_we, dmem_ready, rf_we, exc_taken;
	logic [31:0] fetch_addr, icache_word, rd_instr, rf_rdata_a, rf_rdata_b, alu_op_a, alu_op_b, alu_result;
	logic [31:0] dmem_addr, dmem_wdata, dmem_rdata, rf_wdata, exc_pc, exc_pc_seen;
	logic [4:0] rf_raddr_a, rf_raddr_b, rf_waddr;
	logic [3:0] alu_ctl, byte_lane_enable;
	hint_t rd_hint;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int hilo_at, exc_seen;
	logic [1:0] sz_t [9] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
	logic [1:0] lo_t [9] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
	logic [3:0] be_t [9] = '{4'hF, 4'hE, 4'h7, 4'hC, 4'h3, 4'h8, 4'h4, 4'h2, 4'h1};

	pipe_ctrl u_pipe_ctrl (.ref_clk, .rst_n, .endian_strap, .user_mode, .user_byte_order_flip, .fetch_req,
		.fetch_addr, .icache_word, .icache_valid, .rd_instr, .rd_hint, .rf_raddr_a, .rf_raddr_b, .rf_rdata_a,
		.rf_rdata_b, .alu_op_a, .alu_op_b, .alu_ctl, .alu_result, .alu_overflow, .muldiv_busy, .dmem_req,
		.dmem_we, .dmem_addr, .byte_lane_enable, .dmem_wdata, .dmem_rdata, .dmem_ready, .rf_we, .rf_waddr,
		.rf_wdata, .exc_taken, .exc_pc);

	far_side u_far_side (.ref_clk, .fetch_addr, .icache_word, .icache_valid, .rd_instr, .rd_hint, .rf_raddr_a,
		.rf_raddr_b, .rf_rdata_a, .rf_rdata_b, .alu_op_a, .alu_op_b, .alu_result, .alu_overflow, .dmem_req,
		.dmem_we, .dmem_addr, .byte_lane_enable, .dmem_wdata, .dmem_rdata, .dmem_ready, .rf_we, .rf_waddr,
		.rf_wdata);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Monitors sample registered outputs mid-cycle
	always @(negedge ref_clk) begin
		cyc <= cyc + 1;
		if (rf_we === 1'b1 && rf_waddr === 5'h0A)
			hilo_at <= cyc;
		if (exc_taken === 1'b1) begin
			exc_seen <= exc_seen + 1;
			exc_pc_seen <= exc_pc;
		end
	end

	function automatic logic [31:0] ins(input logic [3:0] op, input logic [1:0] sz, input logic [4:0] rs,
		input logic [4:0] rt, input logic [15:0] lo);
		return {op, sz, rs, rt, lo};
	endfunction : ins

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task clear_all();
		for (int i = 0; i < 256; i++) begin
			u_far_side.imem[i] = 32'h0000_0000;
			u_far_side.dmem[i] = 32'h0000_0000;
		end
		for (int i = 0; i < 32; i++)
			u_far_side.rf[i] = 32'h0000_0000;
		hilo_at = 0;
		exc_seen = 0;
		u_far_side.nlog = 0;
	endtask : clear_all

	task run(input int n);
		rst_n = 1'b0;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (n) @(negedge ref_clk);
	endtask : run

	task t_forward();
		clear_all();
		u_far_side.imem[0] = ins(4'h1, 2'h0, 5'h00, 5'h01, 16'h0005);
		u_far_side.imem[1] = ins(4'h2, 2'h0, 5'h01, 5'h01, 16'h1000);
		u_far_side.imem[2] = ins(4'h2, 2'h0, 5'h02, 5'h01, 16'h1800);
		run(20);
		chk(u_far_side.rf[1], 32'h0000_0005);
		chk(u_far_side.rf[2], 32'h0000_000A);
		chk(u_far_side.rf[3], 32'h0000_000F);
	endtask : t_forward

	task t_lanes(input logic s, input logic u, input logic f, input logic little);
		logic [3:0] e;
		clear_all();
		endian_strap = s;
		user_mode = u;
		user_byte_order_flip = f;
		u_far_side.dmem_wait = 2;
		for (int i = 0; i < 9; i++)
			u_far_side.imem[i] = ins(4'h4, sz_t[i], 5'h00, 5'h00, {14'h0040, lo_t[i]});
		run(60);
		chk(32'(u_far_side.nlog), 32'd9);
		for (int i = 0; i < 9; i++) begin
			e = little ? {be_t[i][0], be_t[i][1], be_t[i][2], be_t[i][3]} : be_t[i];
			chk({28'h0, u_far_side.lane_log[i]}, {28'h0, e});
		end
		endian_strap = 1'b1;
		user_mode = 1'b0;
		user_byte_order_flip = 1'b0;
		u_far_side.dmem_wait = 0;
	endtask : t_lanes

	task t_load();
		clear_all();
		u_far_side.dmem_wait = 3;
		u_far_side.rf[3] = 32'h0000_0011;
		u_far_side.dmem[128] = 32'h1234_5678;
		u_far_side.imem[0] = ins(4'h3, 2'h3, 5'h00, 5'h03, 16'h0200);
		u_far_side.imem[1] = ins(4'h2, 2'h0, 5'h03, 5'h00, 16'h2000);
		u_far_side.imem[2] = ins(4'h2, 2'h0, 5'h03, 5'h00, 16'h2800);
		u_far_side.imem[3] = ins(4'h4, 2'h0, 5'h00, 5'h04, 16'h0203);
		run(40);
		chk(u_far_side.rf[3], 32'h1234_5678);
		chk(u_far_side.rf[4], 32'h0000_0011);
		chk(u_far_side.rf[5], 32'h1234_5678);
		chk(u_far_side.dmem[128], 32'h1234_5611);
		u_far_side.dmem_wait = 0;
	endtask : t_load

	task t_jump();
		clear_all();
		u_far_side.imem[0] = {4'h5, 28'h000_0010};
		u_far_side.imem[1] = ins(4'h1, 2'h0, 5'h00, 5'h0B, 16'h0007);
		u_far_side.imem[2] = ins(4'h1, 2'h0, 5'h00, 5'h0C, 16'h0009);
		u_far_side.imem[16] = ins(4'h1, 2'h0, 5'h00, 5'h0D, 16'h0003);
		run(30);
		chk(u_far_side.rf[11], 32'h0000_0007);
		chk(u_far_side.rf[12], 32'h0000_0000);
		chk(u_far_side.rf[13], 32'h0000_0003);
	endtask : t_jump

	task t_exc();
		clear_all();
		u_far_side.rf[7] = 32'h7FFF_FFFF;
		u_far_side.imem[0] = ins(4'h1, 2'h0, 5'h00, 5'h08, 16'h0001);
		u_far_side.imem[1] = ins(4'h1, 2'h0, 5'h07, 5'h06, 16'h0001);
		u_far_side.imem[2] = ins(4'h1, 2'h0, 5'h00, 5'h09, 16'h0002);
		u_far_side.imem[3] = ins(4'h4, 2'h3, 5'h00, 5'h00, 16'h0100);
		run(30);
		chk(u_far_side.rf[8], 32'h0000_0001);
		chk(u_far_side.rf[6], 32'h0000_0000);
		chk(u_far_side.rf[9], 32'h0000_0000);
		chk(32'(u_far_side.nlog), 32'd0);
		chk(32'(exc_seen), 32'd1);
		chk(exc_pc_seen, 32'h0000_0004);
	endtask : t_exc

	task t_hilo();
		int drop_at;
		clear_all();
		u_far_side.imem[0] = ins(4'h7, 2'h0, 5'h00, 5'h00, 16'h5000);
		muldiv_busy = 1'b1;
		run(25);
		muldiv_busy = 1'b0;
		drop_at = cyc;
		repeat (20) @(negedge ref_clk);
		chk(32'(hilo_at >= drop_at), 32'd1);
	endtask : t_hilo

	task report_and_stop();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	initial begin
		rst_n = 1'b0;
		endian_strap = 1'b1;
		user_mode = 1'b0;
		user_byte_order_flip = 1'b0;
		muldiv_busy = 1'b0;
		t_forward();
		t_lanes(1'b1, 1'b0, 1'b0, 1'b0);
		t_lanes(1'b0, 1'b0, 1'b0, 1'b1);
		t_lanes(1'b1, 1'b1, 1'b1, 1'b1);
		t_lanes(1'b1, 1'b0, 1'b1, 1'b0);
		t_load();
		t_jump();
		t_exc();
		t_hilo();
		report_and_stop();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		report_and_stop();
	end
endmodule : test_five_stage_pipeline_control
`default_nettype wire
